// ---- shared/led_strap_defs.vh ----
`ifndef LED_STRAP_DEFS_VH
`define LED_STRAP_DEFS_VH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each)
`define REG_WAN_MISC_CTRL      8'h00
`define REG_SWITCH_CTRL0       8'h04
`define REG_STRAP_STATUS       8'h08
`define REG_SERIAL_CTRL        8'h0c
`define REG_PORT_STATUS        8'h10

// ==========================================================================
// Field positions
`define WAN_SEL0_LSB           0
`define WAN_SEL1_LSB           4
`define LAN_SEL0_LSB           25
`define LAN_SEL1_LSB           22
`define SEL_W                  3

// ==========================================================================
// Reset values
`define WAN_MISC_RESET         32'h00000000
`define SWITCH_CTRL0_RESET     32'h00000000
`define SERIAL_CTRL_RESET      2'h0

// ==========================================================================
// Indicator source codes
`define SRC_SPEED              3'h0
`define SRC_LINK               3'h1
`define SRC_DUPLEX             3'h2
`define SRC_COLLISION          3'h3
`define SRC_ACTIVITY           3'h4
`define SRC_FDX_COLLISION      3'h5
`define SRC_LINK_ACTIVITY      3'h6

// ==========================================================================
// Bank zero width codes
`define WIDTH_RESERVED         2'h0
`define WIDTH_BYTE             2'h1
`define WIDTH_HALF             2'h2
`define WIDTH_WORD             2'h3

// ==========================================================================
// Timing: least chip reset hold
`define RESET_HOLD_CYCLES      256

`endif

// ---- core/indicator_mux.v ----
`timescale 1ns/10ps
`include "led_strap_defs.vh"

// ==========================================================================
// One indicator: picks one of seven status sources
module indicator_mux (
    input  wire       sys_clk,     // System clock
    input  wire       rst_n,       // Async reset, active low
    input  wire [2:0] sel,         // Source code
    input  wire [6:0] sources,     // Status sources, index equals code
    output reg        led_q        // Registered indicator level
);

    reg led_d;

    // Code 111 is undefined; drive the indicator off
    always @* begin
        if (sel == 3'h7) begin
            led_d = 1'b0;
        end else begin
            led_d = sources[sel];
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            led_q <= 1'b0;
        end else begin
            led_q <= led_d;
        end
    end

endmodule // indicator_mux

// ---- core/led_strap_ctrl.v ----
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "led_strap_defs.vh"

// Summary of operation
// - WAN indicator zero source comes from WAN misc control bits 2..0.
// - WAN indicator one source comes from WAN misc control bits 6..4.
// - Codes 0..6: speed, link, duplex, collision, activity, fdx collision, link+act.
// - Each LAN port indicator zero source from switch control 0 bits 27..25.
// - Each LAN port indicator one source from switch control 0 bits 24..22.
// - During reset WAN indicator pins are inputs sampled as bank width code.
// - Width code 01 byte, 10 half-word, 11 word; 00 reserved.
// - Strapped width applies to memory bank zero, the boot bank.
// - Request-to-send pin sampled in reset as processor clock source strap.
// - In normal operation request-to-send is driven active low.
// - Terminal ready is active-low output; pin also a factory debug strap.
module led_strap_ctrl (
    input  wire        sys_clk,                  // 200 MHz system clock
    input  wire        rst_n,                    // Chip reset, async, active low
    // Wishbone classic slave
    input  wire        wb_cyc_i,                 // Bus cycle
    input  wire        wb_stb_i,                 // Strobe
    input  wire        wb_we_i,                  // Write enable
    input  wire [7:0]  wb_adr_i,                 // Byte address
    input  wire [3:0]  wb_sel_i,                 // Byte lanes
    input  wire [31:0] wb_dat_i,                 // Write data
    output reg  [31:0] wb_dat_o,                 // Read data
    output reg         wb_ack_o,                 // Acknowledge
    // Status sources: {link_act, fdx_col, act, col, duplex, link, speed}
    input  wire [6:0]  wan_status,               // WAN port status
    input  wire [27:0] lan_status,               // Four LAN ports, 7 bits each
    // WAN indicator pins, shared with bank width strap
    input  wire        wan_indicator_zero_i,     // Pin level in
    output wire        wan_indicator_zero_o,     // Pin drive
    output wire        wan_indicator_zero_oe,    // Pin drive enable
    input  wire        wan_indicator_one_i,      // Pin level in
    output wire        wan_indicator_one_o,      // Pin drive
    output wire        wan_indicator_one_oe,     // Pin drive enable
    // LAN indicators, bit n is port n+1
    output wire [3:0]  lan_indicator_zero,       // Indicator zero per port
    output wire [3:0]  lan_indicator_one,        // Indicator one per port
    // Serial modem-control pins
    input  wire        serial_request_to_send_i, // Pin level in
    output wire        serial_request_to_send_n, // Pin drive, active low
    output wire        serial_request_to_send_oe,// Pin drive enable
    input  wire        serial_terminal_ready_i,  // Pin level in
    output wire        serial_terminal_ready_n,  // Pin drive, active low
    output wire        serial_terminal_ready_oe, // Pin drive enable
    input  wire        serial_set_ready_n,       // Set ready, active low
    input  wire        serial_rts_req,           // Serial core asks to send
    input  wire        serial_dtr_req,           // Serial core terminal ready
    // Strap results
    output reg  [1:0]  bank0_width_q,            // Boot bank data width code
    output reg         bank0_width_bad_q,        // Reserved code strapped
    output reg         processor_clock_source_strap, // 0 selects PLL
    output reg         factory_debug_strap_n,    // Debug strap, active low
    output reg         serial_set_ready_q        // Set ready, synchronised, high true
);

    // ======================================================================
    // Registers
    reg [31:0] wan_misc_q;
    reg [31:0] switch_ctrl0_q;
    reg [1:0]  serial_ctrl_q;     // bit0 rts override, bit1 dtr override
    reg        out_en_q;          // Pins driven once out of reset
    reg [1:0]  sync_a_q;          // First stage, WAN strap pins
    reg [1:0]  sync_b_q;
    reg [1:0]  ser_a_q;           // First stage, serial strap pins
    reg [1:0]  ser_b_q;
    reg        dsr_a_q;
    reg        dsr_b_q;
    reg        rts_q;
    reg        dtr_q;

    // Merge a word under byte enables
    function [31:0] merge;
        input [31:0] old;
        input [31:0] upd;
        input [3:0]  sel;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = upd[i*8 +: 8];
                end
            end
        end
    endfunction

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr  = req & wb_we_i;

    // ======================================================================
    // Wishbone slave: ack one cycle after the request, dropped next cycle
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o       <= 1'b0;
            wb_dat_o       <= 32'h00000000;
            wan_misc_q     <= `WAN_MISC_RESET;
            switch_ctrl0_q <= `SWITCH_CTRL0_RESET;
            serial_ctrl_q  <= `SERIAL_CTRL_RESET;
        end else begin
            wb_ack_o <= req;
            if (wr && wb_adr_i == `REG_WAN_MISC_CTRL) begin
                wan_misc_q <= merge(wan_misc_q, wb_dat_i, wb_sel_i);
            end
            if (wr && wb_adr_i == `REG_SWITCH_CTRL0) begin
                switch_ctrl0_q <= merge(switch_ctrl0_q, wb_dat_i, wb_sel_i);
            end
            if (wr && wb_adr_i == `REG_SERIAL_CTRL && wb_sel_i[0]) begin
                serial_ctrl_q <= wb_dat_i[1:0];
            end
            // Unmapped addresses read zero and ignore writes
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    `REG_WAN_MISC_CTRL: wb_dat_o <= wan_misc_q;
                    `REG_SWITCH_CTRL0:  wb_dat_o <= switch_ctrl0_q;
                    `REG_STRAP_STATUS:  wb_dat_o <= {26'h0, factory_debug_strap_n,
                                                     processor_clock_source_strap,
                                                     bank0_width_bad_q, 1'b0,
                                                     bank0_width_q};
                    `REG_SERIAL_CTRL:   wb_dat_o <= {30'h0, serial_ctrl_q};
                    `REG_PORT_STATUS:   wb_dat_o <= {3'h0, serial_set_ready_q,
                                                     lan_status};
                    default:            wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ======================================================================
    // Strap pin synchronisers; run through reset so straps are live then
    always @(posedge sys_clk) begin
        sync_a_q <= {wan_indicator_one_i, wan_indicator_zero_i};
        sync_b_q <= sync_a_q;
        ser_a_q  <= {serial_terminal_ready_i, serial_request_to_send_i};
        ser_b_q  <= ser_a_q;
        dsr_a_q  <= serial_set_ready_n;
        dsr_b_q  <= dsr_a_q;
    end

    // ======================================================================
    // Strap capture: tracks pins while reset holds, freezes at release.
    // Sync output lags the pins by two clocks, well inside the reset hold.
    always @(posedge sys_clk) begin
        if (!out_en_q) begin
            bank0_width_q                <= sync_b_q;
            bank0_width_bad_q            <= (sync_b_q == `WIDTH_RESERVED);
            processor_clock_source_strap <= ser_b_q[0];
            factory_debug_strap_n        <= ser_b_q[1];
        end
    end

    // Pins stay inputs until the first edge after reset release
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_en_q <= 1'b0;
        end else begin
            out_en_q <= 1'b1;
        end
    end

    // ======================================================================
    // Serial modem control; request from core or register override
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rts_q              <= 1'b0;
            dtr_q              <= 1'b0;
            serial_set_ready_q <= 1'b0;
        end else begin
            rts_q              <= serial_rts_req | serial_ctrl_q[0];
            dtr_q              <= serial_dtr_req | serial_ctrl_q[1];
            serial_set_ready_q <= ~dsr_b_q;
        end
    end

    assign serial_request_to_send_n  = ~rts_q;
    assign serial_request_to_send_oe = out_en_q;
    assign serial_terminal_ready_n   = ~dtr_q;
    assign serial_terminal_ready_oe  = out_en_q;

    // ======================================================================
    // WAN indicators
    wire wan_led0;
    wire wan_led1;

    indicator_mux u_wan0 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .sel     (wan_misc_q[`WAN_SEL0_LSB +: `SEL_W]),
        .sources (wan_status),
        .led_q   (wan_led0)
    );

    indicator_mux u_wan1 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .sel     (wan_misc_q[`WAN_SEL1_LSB +: `SEL_W]),
        .sources (wan_status),
        .led_q   (wan_led1)
    );

    assign wan_indicator_zero_o  = wan_led0;
    assign wan_indicator_zero_oe = out_en_q;
    assign wan_indicator_one_o   = wan_led1;
    assign wan_indicator_one_oe  = out_en_q;

    // ======================================================================
    // LAN indicators, one pair per port, sharing the two select fields
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_lan
            indicator_mux u_l0 (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .sel     (switch_ctrl0_q[`LAN_SEL0_LSB +: `SEL_W]),
                .sources (lan_status[p*7 +: 7]),
                .led_q   (lan_indicator_zero[p])
            );
            indicator_mux u_l1 (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .sel     (switch_ctrl0_q[`LAN_SEL1_LSB +: `SEL_W]),
                .sources (lan_status[p*7 +: 7]),
                .led_q   (lan_indicator_one[p])
            );
        end
    endgenerate

endmodule // led_strap_ctrl

// ---- verif/strap_checker.sv ----
`timescale 1ns/10ps
`include "led_strap_defs.vh"
// ==========================================================
// Indicator muxing, strap capture and modem pin polarity
module strap_checker (
    input wire        sys_clk,                     // Clock
    input wire        rst_n,                       // Reset, low
    input wire        wb_cyc_i,                    // Cycle
    input wire        wb_stb_i,                    // Strobe
    input wire        wb_we_i,                     // Write
    input wire [7:0]  wb_adr_i,                    // Address
    input wire [3:0]  wb_sel_i,                    // Lanes
    input wire [31:0] wb_dat_i,                    // Write data
    input wire        wb_ack_o,                    // Ack
    input wire [6:0]  wan_status,                  // WAN sources
    input wire [27:0] lan_status,                  // LAN sources
    input wire        wan_indicator_zero_i,        // Pin in
    input wire        wan_indicator_one_i,         // Pin in
    input wire        wan_indicator_zero_o,        // Pin out
    input wire        wan_indicator_one_o,         // Pin out
    input wire [3:0]  lan_indicator_zero,          // LAN zero
    input wire [3:0]  lan_indicator_one,           // LAN one
    input wire        serial_request_to_send_i,    // Pin in
    input wire        serial_request_to_send_n,    // Pin out
    input wire        serial_terminal_ready_n,     // Pin out
    input wire        serial_rts_req,              // Send request
    input wire        serial_dtr_req,              // Ready request
    input wire [1:0]  bank0_width_q,               // Width code
    input wire        bank0_width_bad_q,           // Reserved flag
    input wire        processor_clock_source_strap // Clock strap
);
    reg [2:0] w0_q, w1_q, l0_q, l1_q;
    reg       frts_q, fdtr_q;
    // Shadow of selects; full-word writes only, which is all the bench issues
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {w1_q, w0_q, l0_q, l1_q, frts_q, fdtr_q} <= 14'h0;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hf) begin
            if (wb_adr_i == `REG_WAN_MISC_CTRL) {w1_q, w0_q} <= {wb_dat_i[6:4], wb_dat_i[2:0]};
            if (wb_adr_i == `REG_SWITCH_CTRL0) {l0_q, l1_q} <= wb_dat_i[27:22];
            if (wb_adr_i == `REG_SERIAL_CTRL) {fdtr_q, frts_q} <= wb_dat_i[1:0];
        end
    end
    // Code 111 shows nothing
    function pick(input [2:0] c, input [6:0] s);
        pick = (c == 3'h7) ? 1'b0 : s[c];
    endfunction
    function [3:0] pick4(input [2:0] c, input [27:0] s);
        pick4 = {pick(c, s[27:21]), pick(c, s[20:14]), pick(c, s[13:7]), pick(c, s[6:0])};
    endfunction
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    a_ack_pulse: assert property (s_taken |=> s_pulse) else $error("ack not one pulse");
    a_wan_zero: assert property ($past(rst_n) |->
        wan_indicator_zero_o == pick($past(w0_q), $past(wan_status))) else $error("wan zero");
    a_wan_one: assert property ($past(rst_n) |->
        wan_indicator_one_o == pick($past(w1_q), $past(wan_status))) else $error("wan one");
    a_lan_zero: assert property ($past(rst_n) |->
        lan_indicator_zero == pick4($past(l0_q), $past(lan_status))) else $error("lan zero");
    a_lan_one: assert property ($past(rst_n) |->
        lan_indicator_one == pick4($past(l1_q), $past(lan_status))) else $error("lan one");
    a_strap_capture: assert property ($rose(rst_n) |=>
        bank0_width_q == $past({wan_indicator_one_i, wan_indicator_zero_i}, 4) &&
        processor_clock_source_strap == $past(serial_request_to_send_i, 4))
        else $error("strap not captured");
    a_strap_frozen: assert property ($past(rst_n, 2) |-> $stable(bank0_width_q))
        else $error("width strap moved");
    a_width_reserved: assert property ($past(rst_n) |->
        bank0_width_bad_q == (bank0_width_q == `WIDTH_RESERVED)) else $error("width flag");
    a_send_low: assert property ($past(rst_n) |->
        serial_request_to_send_n == !($past(serial_rts_req) || $past(frts_q))) else $error("send");
    a_ready_low: assert property ($past(rst_n) |->
        serial_terminal_ready_n == !($past(serial_dtr_req) || $past(fdtr_q))) else $error("ready");
endmodule // strap_checker

bind led_strap_ctrl strap_checker i_strap_checker (.*);

// ---- verif/board_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Board side: strap resistors, indicator loads, modem partner
module board_model (
    input  wire       wan_indicator_zero_o,      // Drive
    input  wire       wan_indicator_zero_oe,     // Enable
    input  wire       wan_indicator_one_o,       // Drive
    input  wire       wan_indicator_one_oe,      // Enable
    input  wire       serial_request_to_send_n,  // Drive
    input  wire       serial_request_to_send_oe, // Enable
    input  wire       serial_terminal_ready_n,   // Drive
    input  wire       serial_terminal_ready_oe,  // Enable
    input  wire [1:0] width_strap,               // Strapped width
    input  wire       dsr_assert,                // Equipment ready
    output wire       wan_indicator_zero_i,      // Pin level
    output wire       wan_indicator_one_i,       // Pin level
    output wire       serial_request_to_send_i,  // Pin level
    output wire       serial_terminal_ready_i,   // Pin level
    output wire       serial_set_ready_n         // Ready, low true
);
    // Released pins fall to their resistor, never to a stale level
    assign wan_indicator_zero_i = wan_indicator_zero_oe ? wan_indicator_zero_o
                                                        : width_strap[0];
    assign wan_indicator_one_i = wan_indicator_one_oe ? wan_indicator_one_o
                                                      : width_strap[1];
    assign serial_request_to_send_i = serial_request_to_send_oe ? serial_request_to_send_n
                                                                : 1'b0;
    assign serial_terminal_ready_i = serial_terminal_ready_oe ? serial_terminal_ready_n
                                                              : 1'b1;
    assign serial_set_ready_n = !dsr_assert;
endmodule // board_model

// ---- verif/tb_led_strap_ctrl.sv ----
`timescale 1ns/10ps
`include "led_strap_defs.vh"
// ==========================================================
// Bench for the indicator and strap block
module tb_led_strap_ctrl;
    reg         sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, serial_rts_req, serial_dtr_req;
    reg         dsr_assert;
    reg  [7:0]  wb_adr_i;
    reg  [3:0]  wb_sel_i;
    reg  [31:0] wb_dat_i, rd;
    reg  [6:0]  wan_status;
    reg  [27:0] lan_status;
    reg  [1:0]  width_strap;
    wire [31:0] wb_dat_o;
    wire [3:0]  lan_indicator_zero, lan_indicator_one;
    wire [1:0]  bank0_width_q;
    wire        wb_ack_o, wan_indicator_zero_i, wan_indicator_zero_o, wan_indicator_zero_oe;
    wire        wan_indicator_one_i, wan_indicator_one_o, wan_indicator_one_oe, bank0_width_bad_q;
    wire        serial_request_to_send_i, serial_request_to_send_n, serial_request_to_send_oe;
    wire        serial_terminal_ready_i, serial_terminal_ready_n, serial_terminal_ready_oe;
    wire        serial_set_ready_n, processor_clock_source_strap, factory_debug_strap_n;
    wire        serial_set_ready_q;
    integer     n_fail = 0, checked = 0, i, p;

    led_strap_ctrl i_led_strap_ctrl (.*);
    board_model i_board_model (.*);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    function pk(input [2:0] c, input [6:0] s);
        pk = (c == 3'h7) ? 1'b0 : s[c];
    endfunction
    function [3:0] pk4(input [2:0] c, input [27:0] s);
        pk4 = {pk(c, s[27:21]), pk(c, s[20:14]), pk(c, s[13:7]), pk(c, s[6:0])};
    endfunction
    task chk(input string what, input [31:0] exp, input [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic cycle; the wait is bounded so a dead slave cannot hang us
    task wb(input [7:0] a, input w, input [31:0] d);
        integer t;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        t = 0;
        do begin
            @(posedge sys_clk);
            t = t + 1;
        end while (wb_ack_o !== 1'b1 && t < 50);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        chk("ack", 1, wb_ack_o);
    endtask
    task do_reset(input [1:0] code);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        width_strap <= code;
        repeat (260) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
    // Every width code, the reserved one too, each across a fresh reset
    task t_straps;
        for (i = 0; i < 4; i = i + 1) begin
            do_reset(i[1:0]);
            chk("width", i, bank0_width_q);
            chk("reserved flag", i == 0, bank0_width_bad_q);
            chk("clock strap", 0, processor_clock_source_strap);
            chk("debug strap", 1, factory_debug_strap_n);
            chk("pin driven", 1, wan_indicator_zero_oe & wan_indicator_one_oe);
            wb(`REG_STRAP_STATUS, 1, 32'hffffffff);
            wb(`REG_STRAP_STATUS, 0, 0);
            chk("strap status", 32'h20 | (i == 0 ? 8 : 0) | i, rd);
        end
    endtask
    // All eight codes on both selects, each against two status patterns
    task t_indicators;
        reg [2:0] c;
        for (i = 0; i < 8; i = i + 1) begin
            c = i;
            wb(`REG_WAN_MISC_CTRL, 1, {25'h0, ~c, 1'b0, c});
            wb(`REG_SWITCH_CTRL0, 1, {4'h0, c, ~c, 22'h0});
            wb(`REG_WAN_MISC_CTRL, 0, 0);
            chk("wan misc readback", {25'h0, ~c, 1'b0, c}, rd);
            wb(`REG_SWITCH_CTRL0, 0, 0);
            chk("switch ctrl0 readback", {4'h0, c, ~c, 22'h0}, rd);
            for (p = 0; p < 2; p = p + 1) begin
                @(posedge sys_clk);
                wan_status <= p ? 7'h2a : 7'h55;
                lan_status <= p ? 28'h3c5a96e : 28'hc3a5691;
                repeat (2) @(posedge sys_clk);
                chk("wan zero", pk(c, wan_status), wan_indicator_zero_o);
                chk("wan one", pk(~c, wan_status), wan_indicator_one_o);
                chk("lan zero", pk4(c, lan_status), lan_indicator_zero);
                chk("lan one", pk4(~c, lan_status), lan_indicator_one);
            end
        end
    endtask
    task t_serial;
        wb(`REG_SERIAL_CTRL, 1, 32'h3);
        repeat (2) @(posedge sys_clk);
        chk("forced pins", 0, serial_request_to_send_n | serial_terminal_ready_n);
        wb(`REG_SERIAL_CTRL, 1, 32'h0);
        wb(8'h3c, 0, 0);
        chk("unmapped", 0, rd);
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge sys_clk);
            {serial_rts_req, serial_dtr_req, dsr_assert} <= {i[1:0], i[0]};
            repeat (4) @(posedge sys_clk);
            chk("send", !i[1], serial_request_to_send_n);
            chk("terminal", !i[0], serial_terminal_ready_n);
            chk("set ready", i[0], serial_set_ready_q);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, serial_rts_req, serial_dtr_req, dsr_assert} <= 7'h0;
        {wb_adr_i, wb_dat_i, wan_status, lan_status, width_strap} <= 0;
        wb_sel_i <= 4'hf;
        t_straps;
        t_indicators;
        t_serial;
        conclude;
    end
    // Run needs about 1260 cycles; cut off well past that
    initial begin
        #50000;
        n_fail = n_fail + 1;
        conclude;
    end
endmodule // tb_led_strap_ctrl
